// >>> osr_consts.svh
// constants of the output serializer: register indices, field positions, reset values
// assumes inclusion by the package and the design files; definitions only
`ifndef OSR_CONSTS_SVH
`define OSR_CONSTS_SVH

// register indices; byte address is four times the index
`define OSR_IDX_TIMING 8'haa
`define OSR_IDX_HOLD 8'hab
`define OSR_IDX_PER_LO 8'hac
`define OSR_IDX_PER_HI 8'had
`define OSR_IDX_CTRL 8'hb0
`define OSR_IDX_STATUS 8'hb1

// timing register fields
`define OSR_GRP_MSB 7
`define OSR_GRP_LSB 5
`define OSR_EDGE_MSB 4
`define OSR_EDGE_LSB 3
`define OSR_DIV_MSB 2
`define OSR_DIV_LSB 0

// control register fields
`define OSR_CTRL_EN_BIT 0
`define OSR_CTRL_EOD_MSB 2
`define OSR_CTRL_EOD_LSB 1

// reset values
`define OSR_RST_BYTE 8'h00
`define OSR_RST_HI 7'h00
`define OSR_RST_EMPTY 1'b1

`endif

// >>> osr_pkg.sv
// types of the output serializer
// assumes osr_consts.svh is on the include path
package osr_pkg;
    `include "osr_consts.svh"

    typedef enum logic [1:0] {
        EOD_SHUTDOWN = 2'h0,
        EOD_REPEAT = 2'h1,
        EOD_ZEROS = 2'h2,
        EOD_ONES = 2'h3
    } osr_eod_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_RAMP_UP,
        ST_SEND,
        ST_RAMP_DOWN
    } osr_state_t;
endpackage : osr_pkg

// >>> osr_tick_if.sv
// link between the serializer core and its clock divider
// assumes both ends share ref_clk
interface osr_tick_if;
    logic [2:0] div;
    logic tick;
    modport src (input div, output tick);
    modport dst (output div, input tick);
endinterface : osr_tick_if

// >>> osr_clk_div.sv
// serializer clock divider: one tick every div+1 system clocks
// assumes synchronous active high reset and a clock enable from the top
module osr_clk_div
    import osr_pkg::*;
(
    // clock and control
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    // tick toward the core
    osr_tick_if.src tk
);
    logic [2:0] cnt;

    assign tk.tick = ce && (cnt >= tk.div);

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cnt <= 3'h0;
        end else if (ce) begin
            cnt <= tk.tick ? 3'h0 : cnt + 3'h1;
        end
    end

    property p_div_one;
        @(posedge ref_clk) disable iff (rst)
        (ce && tk.div == 3'h0) |-> tk.tick;
    endproperty
    a_div_one: assert property (p_div_one) else $error("divide by one lost a tick");

    property p_div_gap;
        @(posedge ref_clk) disable iff (rst)
        tk.tick ##1 (ce && tk.div != 3'h0 && tk.div == $past(tk.div)) |-> !tk.tick;
    endproperty
    a_div_gap: assert property (p_div_gap) else $error("ticks too close together");
endmodule : osr_clk_div

// >>> osr_top.sv
// output serializer timing and data feed, with its APB register slave
// assumes one clock, synchronous reset, APB master on the same clock
// What this block does
// - groups of 1 to 8 symbols, field 7:5
// - group field holds symbol count minus one
// - group size taken when holding byte written
// - ramp lasts 8 x (div+1) x (edge+1) clocks
// - serializer clock is system clock over div+1
// - holding write clears the empty flag
// - one registered pulse after each holding write
// - group byte sent least significant bit first
// - low period byte at index 0xac
// - upper seven period bits at index 0xad
// - one symbol per period x (div+1) clocks; period 0 acts as 1
// - period high bit 7 reads zero, ignores writes
// - one byte pipeline with empty-flag handshake
// - out of data: shutdown, repeat, zeros, ones
`include "osr_consts.svh"
module osr_top
    import osr_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    // clock, reset, enable
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // amplifier and oscillator controls
    output logic pa_on,
    output logic pa_ramp_up,
    output logic pa_ramp_down,
    output logic lc_oscillator_on,
    output logic divider_on,
    // symbol stream
    output logic symbol_data,
    output logic symbol_strobe,
    output logic data_write_pulse,
    output logic holding_empty
);
    osr_tick_if tk ();

    logic [7:0] serializer_timing_config;
    logic [7:0] symbol_group_holding;
    logic [7:0] symbol_period_low;
    logic [6:0] symbol_period_high;
    logic enable;
    osr_eod_t eod;
    logic [2:0] hold_len;
    logic hold_valid;
    logic rd_done;
    logic [31:0] next_rdata;
    logic [7:0] idx;
    logic addr_hi_zero;
    logic mapped;
    logic access;
    logic wr;
    logic wr_data;
    logic take;

    osr_state_t state;
    logic [7:0] shift_q;
    logic [7:0] last_byte;
    logic [2:0] cur_len;
    logic [2:0] sym_idx;
    logic [14:0] per_cnt;
    logic [4:0] ramp_cnt;
    logic [14:0] period;
    logic [14:0] period_m1;
    logic [4:0] ramp_last;
    logic sym_end;
    logic group_last;

    osr_clk_div u_div (
        .ref_clk(ref_clk),
        .rst(rst),
        .ce(ce),
        .tk(tk)
    );

    assign tk.div = serializer_timing_config[`OSR_DIV_MSB:`OSR_DIV_LSB];

    // apb decode
    assign idx = paddr[9:2];
    assign addr_hi_zero = (ADDR_W <= 10) ? 1'b1 : (paddr >> 10) == '0;
    always_comb begin
        mapped = addr_hi_zero;
        next_rdata = 32'h0000_0000;
        case (idx)
            `OSR_IDX_TIMING: next_rdata[7:0] = serializer_timing_config;
            `OSR_IDX_HOLD: next_rdata[7:0] = symbol_group_holding;
            `OSR_IDX_PER_LO: next_rdata[7:0] = symbol_period_low;
            `OSR_IDX_PER_HI: next_rdata[7:0] = {1'b0, symbol_period_high};
            `OSR_IDX_CTRL: next_rdata[2:0] = {eod, enable};
            `OSR_IDX_STATUS: next_rdata[2:0] = {hold_valid, state != ST_IDLE, holding_empty};
            default: mapped = 1'b0;
        endcase
        if (!addr_hi_zero) begin
            next_rdata = 32'h0000_0000;
        end
    end

    assign pready = penable && ce && rd_done;
    assign pslverr = pready && !mapped;
    assign access = psel && pready;
    assign wr = access && pwrite && mapped;
    assign wr_data = wr && idx == `OSR_IDX_HOLD;

    // read data captured once per transfer
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
            rd_done <= 1'b0;
        end else if (ce) begin
            if (access) begin
                rd_done <= 1'b0;
            end else if (psel && !rd_done) begin
                prdata <= pwrite ? 32'h0000_0000 : next_rdata;
                rd_done <= 1'b1;
            end
        end
    end

    // configuration registers
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            serializer_timing_config <= `OSR_RST_BYTE;
            symbol_period_low <= `OSR_RST_BYTE;
            symbol_period_high <= `OSR_RST_HI;
            enable <= 1'b0;
            eod <= EOD_SHUTDOWN;
        end else if (ce && wr) begin
            case (idx)
                `OSR_IDX_TIMING: serializer_timing_config <= pwdata[7:0];
                `OSR_IDX_PER_LO: symbol_period_low <= pwdata[7:0];
                `OSR_IDX_PER_HI: symbol_period_high <= pwdata[6:0];
                `OSR_IDX_CTRL: begin
                    enable <= pwdata[`OSR_CTRL_EN_BIT];
                    eod <= osr_eod_t'(pwdata[`OSR_CTRL_EOD_MSB:`OSR_CTRL_EOD_LSB]);
                end
                default: ;
            endcase
        end
    end

    // holding register, group size snapshot and notification pulse
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            symbol_group_holding <= `OSR_RST_BYTE;
            hold_len <= 3'h0;
            data_write_pulse <= 1'b0;
        end else if (ce) begin
            data_write_pulse <= wr_data;
            if (wr_data) begin
                symbol_group_holding <= pwdata[7:0];
                hold_len <= serializer_timing_config[`OSR_GRP_MSB:`OSR_GRP_LSB];
            end
        end
    end

    // one byte pipeline handshake
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            holding_empty <= `OSR_RST_EMPTY;
            hold_valid <= 1'b0;
        end else if (ce) begin
            if (wr_data) begin
                holding_empty <= 1'b0;
            end else if (take) begin
                holding_empty <= 1'b1;
            end
            hold_valid <= data_write_pulse || (hold_valid && !take);
        end
    end

    // symbol timing
    assign period = {symbol_period_high, symbol_period_low};
    assign period_m1 = (period == 15'h0000) ? 15'h0000 : period - 15'h0001;
    assign sym_end = tk.tick && per_cnt >= period_m1;
    assign group_last = sym_idx >= cur_len;
    assign ramp_last = {serializer_timing_config[`OSR_EDGE_MSB:`OSR_EDGE_LSB], 3'h7};

    // a fresh byte is never taken in the cycle it is written or announced
    assign take = ce && enable && hold_valid && !wr_data && !data_write_pulse
        && (state == ST_IDLE || (state == ST_SEND && sym_end && group_last));

    // serializer sequencer
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state <= ST_IDLE;
            shift_q <= 8'h00;
            last_byte <= 8'h00;
            cur_len <= 3'h0;
            sym_idx <= 3'h0;
            per_cnt <= 15'h0000;
            ramp_cnt <= 5'h00;
            symbol_strobe <= 1'b0;
        end else if (ce) begin
            symbol_strobe <= 1'b0;
            case (state)
                ST_IDLE: begin
                    ramp_cnt <= 5'h00;
                    if (take) begin
                        shift_q <= symbol_group_holding;
                        last_byte <= symbol_group_holding;
                        cur_len <= hold_len;
                        state <= ST_RAMP_UP;
                    end
                end
                ST_RAMP_UP: begin
                    if (!enable) begin
                        state <= ST_RAMP_DOWN;
                        ramp_cnt <= 5'h00;
                    end else if (tk.tick) begin
                        ramp_cnt <= ramp_cnt + 5'h01;
                        if (ramp_cnt >= ramp_last) begin
                            state <= ST_SEND;
                            per_cnt <= 15'h0000;
                            sym_idx <= 3'h0;
                            symbol_strobe <= 1'b1;
                        end
                    end
                end
                ST_SEND: begin
                    if (!enable) begin
                        state <= ST_RAMP_DOWN;
                        ramp_cnt <= 5'h00;
                    end else if (sym_end) begin
                        per_cnt <= 15'h0000;
                        symbol_strobe <= 1'b1;
                        if (!group_last) begin
                            shift_q <= {1'b0, shift_q[7:1]};
                            sym_idx <= sym_idx + 3'h1;
                        end else begin
                            sym_idx <= 3'h0;
                            if (take) begin
                                shift_q <= symbol_group_holding;
                                last_byte <= symbol_group_holding;
                                cur_len <= hold_len;
                            end else begin
                                case (eod)
                                    EOD_REPEAT: shift_q <= last_byte;
                                    EOD_ZEROS: shift_q <= 8'h00;
                                    EOD_ONES: shift_q <= 8'hff;
                                    default: begin
                                        state <= ST_RAMP_DOWN;
                                        ramp_cnt <= 5'h00;
                                        symbol_strobe <= 1'b0;
                                    end
                                endcase
                            end
                        end
                    end else if (tk.tick) begin
                        per_cnt <= per_cnt + 15'h0001;
                    end
                end
                ST_RAMP_DOWN: begin
                    if (tk.tick) begin
                        ramp_cnt <= ramp_cnt + 5'h01;
                        if (ramp_cnt >= ramp_last) begin
                            state <= ST_IDLE;
                        end
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // power sequencing follows the sequencer state
    assign symbol_data = shift_q[0];
    assign pa_ramp_up = state == ST_RAMP_UP;
    assign pa_ramp_down = state == ST_RAMP_DOWN;
    assign pa_on = state != ST_IDLE;
    assign lc_oscillator_on = state != ST_IDLE;
    assign divider_on = state != ST_IDLE;

    property p_write_clears_empty;
        @(posedge ref_clk) disable iff (rst)
        wr_data |=> !holding_empty;
    endproperty
    a_write_clears_empty: assert property (p_write_clears_empty) else $error("empty flag not cleared");

    property p_pulse_after_write;
        @(posedge ref_clk) disable iff (rst)
        wr_data |=> data_write_pulse && symbol_group_holding == $past(pwdata[7:0]) ##1 !data_write_pulse;
    endproperty
    a_pulse_after_write: assert property (p_pulse_after_write) else $error("notify pulse wrong");

    property p_take_sets_empty;
        @(posedge ref_clk) disable iff (rst)
        take |=> holding_empty && !hold_valid;
    endproperty
    a_take_sets_empty: assert property (p_take_sets_empty) else $error("transfer did not free holding");

    property p_size_latched;
        @(posedge ref_clk) disable iff (rst)
        wr_data |=> hold_len == $past(serializer_timing_config[7:5]);
    endproperty
    a_size_latched: assert property (p_size_latched) else $error("group size not captured");

    property p_len_loaded;
        @(posedge ref_clk) disable iff (rst)
        take |=> cur_len == $past(hold_len) && shift_q == $past(symbol_group_holding);
    endproperty
    a_len_loaded: assert property (p_len_loaded) else $error("group not loaded");

    property p_lsb_first;
        @(posedge ref_clk) disable iff (rst)
        (state == ST_SEND && enable && sym_end && !group_last) |=> shift_q == {1'b0, $past(shift_q[7:1])};
    endproperty
    a_lsb_first: assert property (p_lsb_first) else $error("shift order wrong");

    property p_period_count;
        @(posedge ref_clk) disable iff (rst)
        (state == ST_SEND && enable && tk.tick && per_cnt < period_m1) |=> per_cnt == $past(per_cnt) + 15'h0001;
    endproperty
    a_period_count: assert property (p_period_count) else $error("period counter stalled");

    property p_ramp_end;
        @(posedge ref_clk) disable iff (rst)
        (state == ST_RAMP_UP && enable && tk.tick && ramp_cnt == ramp_last) |=> state == ST_SEND && symbol_strobe;
    endproperty
    a_ramp_end: assert property (p_ramp_end) else $error("ramp up did not end");

    property p_hi_bit7;
        @(posedge ref_clk) disable iff (rst)
        (pready && psel && !pwrite && idx == `OSR_IDX_PER_HI) |-> prdata == {24'h0, 1'b0, symbol_period_high};
    endproperty
    a_hi_bit7: assert property (p_hi_bit7) else $error("reserved bit read as one");

    property p_eod_zeros;
        @(posedge ref_clk) disable iff (rst)
        (state == ST_SEND && enable && sym_end && group_last && !take && eod == EOD_ZEROS) |=> shift_q == 8'h00;
    endproperty
    a_eod_zeros: assert property (p_eod_zeros) else $error("zero fill missing");

    c_take_in_send: cover property (@(posedge ref_clk) disable iff (rst) take && state == ST_SEND);
    c_ramp_down: cover property (@(posedge ref_clk) disable iff (rst) state == ST_SEND ##1 state == ST_RAMP_DOWN);
    c_repeat: cover property (@(posedge ref_clk) disable iff (rst) sym_end && group_last && !take && eod == EOD_REPEAT);
    c_five_sym: cover property (@(posedge ref_clk) disable iff (rst) take && hold_len == 3'h4);
endmodule : osr_top

// >>> osr_pa_model.sv
// far-side model: watches the amplifier ramp controls, the write pulse and the symbol stream
// assumes the serializer's ref_clk and rst; clr restarts every observation
module osr_pa_model (
    // clock, reset, clear
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clr,
    // from the serializer
    input wire logic pa_ramp_up,
    input wire logic pa_ramp_down,
    input wire logic symbol_strobe,
    input wire logic symbol_data,
    input wire logic data_write_pulse,
    // observations
    output logic [5:0] nsym,
    output logic [31:0] bits,
    output logic [15:0] gap,
    output logic [15:0] up_len,
    output logic [15:0] dn_len,
    output logic [3:0] npulse
);
    timeunit 1ns;
    timeprecision 1ps;
    logic strobe_d;
    logic [15:0] cnt;
    always_ff @(posedge ref_clk) begin
        if (rst || clr) begin
            nsym <= 6'h00;
            bits <= 32'h0;
            gap <= 16'h0;
            up_len <= 16'h0;
            dn_len <= 16'h0;
            npulse <= 4'h0;
            strobe_d <= 1'b0;
            cnt <= 16'h0;
        end else begin
            strobe_d <= symbol_strobe;
            cnt <= symbol_strobe ? 16'h1 : cnt + 16'h1;
            if (symbol_strobe) begin
                gap <= cnt;
            end
            // sample one clock into the symbol, clear of its launching edge
            if (strobe_d && nsym < 6'h20) begin
                bits[nsym[4:0]] <= symbol_data;
                nsym <= nsym + 6'h1;
            end
            up_len <= up_len + {15'h0, pa_ramp_up};
            dn_len <= dn_len + {15'h0, pa_ramp_down};
            npulse <= npulse + {3'h0, data_write_pulse};
        end
    end
endmodule : osr_pa_model

// >>> output_serializer_timing_data_tb.sv
// self-checking bench of osr_top over APB, with the far-side model
// assumes the design files and osr_pa_model are compiled first
module output_serializer_timing_data_tb
    import osr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [11:0] A_TIM = 12'h2a8, A_HOLD = 12'h2ac, A_LO = 12'h2b0;
    localparam logic [11:0] A_HI = 12'h2b4, A_CTL = 12'h2c0, A_STAT = 12'h2c4;
    localparam logic [11:0] REGS [4] = '{A_TIM, A_HOLD, A_LO, A_HI};
    logic ref_clk, rst, ce, psel, penable, pwrite, clr, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, bits;
    logic pready, pslverr, pa_on, pa_ramp_up, pa_ramp_down, symbol_data, symbol_strobe;
    logic data_write_pulse, holding_empty, lc_oscillator_on, divider_on;
    logic [5:0] nsym;
    logic [15:0] gap, up_len, dn_len;
    logic [3:0] npulse;
    logic [7:0] lfsr = 8'h1f;
    logic [7:0] rv;
    int err_count = 0;
    int cmp_count = 0;

    osr_top #(.ADDR_W(12)) dut (.ref_clk(ref_clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pa_on(pa_on), .pa_ramp_up(pa_ramp_up), .pa_ramp_down(pa_ramp_down),
        .lc_oscillator_on(lc_oscillator_on), .divider_on(divider_on),
        .symbol_data(symbol_data), .symbol_strobe(symbol_strobe),
        .data_write_pulse(data_write_pulse), .holding_empty(holding_empty));
    osr_pa_model far (.ref_clk(ref_clk), .rst(rst), .clr(clr), .pa_ramp_up(pa_ramp_up),
        .pa_ramp_down(pa_ramp_down), .symbol_strobe(symbol_strobe), .symbol_data(symbol_data),
        .data_write_pulse(data_write_pulse), .nsym(nsym), .bits(bits), .gap(gap), .up_len(up_len),
        .dn_len(dn_len), .npulse(npulse));

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    function automatic logic [7:0] nxt(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : nxt

    function automatic logic [31:0] exp_bits(input logic [2:0] g1, input logic [7:0] b1,
        input logic [2:0] g2, input logic [7:0] b2, input logic [1:0] e);
        logic [31:0] r;
        r = 32'h0;
        for (int i = 0; i <= g1; i++) r[i] = b1[i];
        for (int i = 0; i <= g2; i++) begin
            r[g1 + 1 + i] = b2[i];
            if (e != 2'h0) r[g1 + g2 + 2 + i] = (e == 2'h1) ? b2[i] : (e == 2'h3);
        end
        return r;
    endfunction : exp_bits

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : check

    task automatic test_done();
        $display("comparisons %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : test_done

    task automatic clk_n(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : clk_n

    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        int n;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do @(posedge ref_clk); while (pready !== 1'b1 && ++n < 50);
        if (n >= 50) err_count++;
        rv = prdata[7:0];
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic clear_far();
        @(posedge ref_clk);
        clr <= 1'b1;
        @(posedge ref_clk);
        clr <= 1'b0;
    endtask : clear_far

    task automatic run(input logic [2:0] dv, input logic [1:0] ed, input logic [7:0] per,
        input logic [2:0] g1, input logic [7:0] b1, input logic [2:0] g2, input logic [7:0] b2,
        input logic [1:0] e);
        int n, t, rmp;
        logic [31:0] m;
        n = g1 + g2 + 2 + ((e != 2'h0) ? g2 + 1 : 0);
        rmp = 8 * (dv + 1) * (ed + 1);
        m = (32'h1 << n) - 32'h1;
        apb(1'b1, A_TIM, {g1, ed, dv});
        apb(1'b1, A_LO, per);
        apb(1'b1, A_HI, 8'h00);
        apb(1'b1, A_CTL, {5'h0, e, 1'b0});
        clear_far();
        apb(1'b1, A_HOLD, b1);
        apb(1'b1, A_CTL, {5'h0, e, 1'b1});
        t = 0;
        do clk_n(1); while (holding_empty !== 1'b1 && ++t < 50);
        check(holding_empty, 1'b1);
        check({pa_on, lc_oscillator_on, divider_on, pa_ramp_up}, 4'hf);
        // next group size applies to the next byte only
        apb(1'b1, A_TIM, {g2, ed, dv});
        apb(1'b1, A_HOLD, b2);
        t = 0;
        do clk_n(1); while (nsym < n && ++t < 4000);
        if (e != 2'h0) apb(1'b1, A_CTL, 8'h00);
        t = 0;
        do clk_n(1); while (pa_on !== 1'b0 && ++t < 1000);
        check({pa_on, lc_oscillator_on, divider_on, pa_ramp_down}, 4'h0);
        if (e != 2'h0) check(nsym >= n, 1'b1);
        check(bits & m, exp_bits(g1, b1, g2, b2, e) & m);
        check(gap, per * (dv + 1));
        check(up_len + dv + 1 >= rmp && up_len <= rmp + dv + 1, 1'b1);
        check(dn_len + dv + 1 >= rmp && dn_len <= rmp + dv + 1, 1'b1);
        if (e == 2'h0) check(nsym, n);
        $display("test stream eod %0d done", e);
    endtask : run

    initial begin
        repeat (60000) @(posedge ref_clk);
        err_count++;
        $display("wrong value at %0t: watchdog expired", $time);
        test_done();
    end

    initial begin
        rst = 1'b1;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        clr = 1'b0;
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        clk_n(2);
        foreach (REGS[i]) begin
            apb(1'b0, REGS[i], 8'h00);
            check(rv, 8'h00);
        end
        apb(1'b0, A_STAT, 8'h00);
        check(rv[0], 1'b1);
        $display("test reset done");
        repeat (8) begin
            lfsr = nxt(lfsr);
            apb(1'b1, A_LO, lfsr);
            apb(1'b1, A_HI, lfsr);
            apb(1'b1, A_TIM, lfsr);
            apb(1'b0, A_LO, 8'h00);
            check(rv, lfsr);
            apb(1'b0, A_HI, 8'h00);
            check(rv, {1'b0, lfsr[6:0]});
            apb(1'b0, A_TIM, 8'h00);
            check(rv, lfsr);
        end
        // clock enable low freezes the register slave mid-transfer
        ce <= 1'b0;
        fork
            apb(1'b0, A_LO, 8'h00);
            begin
                repeat (6) @(posedge ref_clk);
                check(pready, 1'b0);
                ce <= 1'b1;
            end
        join
        check(rv, lfsr);
        apb(1'b1, 12'h6a8, 8'h5a);
        check(er, 1'b1);
        apb(1'b0, 12'h2b8, 8'h00);
        check({er, rv}, {1'b1, 8'h00});
        $display("test registers done");
        clear_far();
        apb(1'b1, A_HOLD, 8'h96);
        clk_n(4);
        check(npulse, 4'h1);
        check(holding_empty, 1'b0);
        apb(1'b0, A_HOLD, 8'h00);
        check(rv, 8'h96);
        $display("test holding write done");
        // divider 2 keeps the serializer clock in its recommended band
        for (int e = 0; e < 4; e++) begin
            lfsr = nxt(lfsr);
            run(3'h2, e[1:0], 8'h02, 3'h4, lfsr, (e == 0) ? 3'h1 : 3'h7, ~lfsr, e[1:0]);
        end
        repeat (4) begin
            lfsr = nxt(lfsr);
            run((lfsr[2:0] < 3'h2) ? 3'h2 : lfsr[2:0], lfsr[4:3], {7'h0, lfsr[5]} + 8'h02,
                (lfsr[7:5] == 3'h0) ? 3'h1 : lfsr[7:5], nxt(lfsr), lfsr[3:1] | 3'h1, ~lfsr, lfsr[1:0]);
        end
        test_done();
    end
endmodule : output_serializer_timing_data_tb
